// [core/bridge_pm_window_defines.vh]
`ifndef BRIDGE_PM_WINDOW_DEFINES_VH
`define BRIDGE_PM_WINDOW_DEFINES_VH

// Register byte offsets
`define OFF_PM_CTRL_STATUS 8'h94
`define OFF_WIN0_XLAT_BASE 8'h98
`define OFF_WIN0_SETUP 8'hc0
`define OFF_WIN0_SETUP_DOC 8'h9c
`define OFF_WIN0_BASE 8'hc4

// Power management word fields
`define PM_STATE_LSB 0
`define PM_STATE_MSB 1
`define PM_EVT_EN_BIT 8
`define PM_EVT_STS_BIT 15
`define PM_STATE_D0 2'h0
`define PM_STATE_D1 2'h1
`define PM_STATE_D2 2'h2
`define PM_STATE_D3 2'h3

// Window setup fields
`define SETUP_TYPE_BIT 0
`define SETUP_AWIDTH_LSB 1
`define SETUP_AWIDTH_MSB 2
`define SETUP_PREFETCH_BIT 3
`define SETUP_MASK_LSB 12
`define SETUP_MASK_MSB 30
`define SETUP_ENABLE_BIT 31

// Reset values
`define RST_PM_STATE 2'h0
`define RST_XLAT_BASE 20'h00000
`define RST_AWIDTH 2'h0
`define RST_PREFETCH 1'h0
`define RST_SIZE_MASK 19'h7ffff
`define RST_WIN_BASE 20'h00000

// Field widths
`define PAGE_LSB 12
`define PAGE_W 20
`define MASK_W 19

`endif

// [core/bridge_pm_window_regs.v]
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "bridge_pm_window_defines.vh"

// What this block does
// - Two-bit power state at bits 1:0, reset D0; 00 is D0, 11 is D3.
// - Writes of unimplemented D1 or D2 codes are dropped, state kept.
// - Moving D3 to D0 by write internally resets block, secondary reset untouched.
// - Bit 8 sticky event enable, reset 0; event output only while set.
// - Bit 15 sticky event status, set by event, cleared by writing 1.
// - Data select, data scale and data byte fields read zero, ignore writes.
// - Bit 22 reads 0: no B2/B3 on secondary bus in D3hot.
// - Bit 23 reads 0: secondary bus power/clock control disabled.
// - Translated base bits 31:12 read-write, reset 0; bits 11:0 read zero.
// - Window hits get translated base in upper bits chosen by size mask.
// - Setup bit 0 reads 0, memory space window.
// - Setup bits 2:1 address width, reset 00, host read-only, preload set.
// - Size mask bits 30:12, reset 7FFFFh, make window base bits writable.
// - Setup bit 31 enable resets 1, stays 1 on zero writes.
module bridge_pm_window_regs (
   input wire i_sys_clk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [31:0] o_rdata,
   input wire i_preload_valid,
   input wire [31:0] i_preload_data,
   input wire i_power_event,
   output reg o_power_event_out_n,
   output reg [1:0] o_power_state,
   output reg o_internal_reset,
   input wire i_dn_valid,
   input wire [31:0] i_dn_addr,
   output reg o_dn_valid,
   output reg o_dn_hit,
   output reg [31:0] o_dn_addr
);
   localparam WIN_ENABLE = 1'b1;

   // Power management state
   reg [1:0] pm_state_ff;
   reg [1:0] nxt_pm_state;
   reg evt_en_ff;
   reg nxt_evt_en;
   reg evt_sts_ff;
   reg nxt_evt_sts;
   reg soft_rst_ff;
   reg nxt_soft_rst;

   // Window state
   reg [`PAGE_W-1:0] xlat_base_ff;
   reg [`PAGE_W-1:0] nxt_xlat_base;
   reg [`PAGE_W-1:0] win_base_ff;
   reg [`PAGE_W-1:0] nxt_win_base;
   reg [1:0] awidth_ff;
   reg prefetch_ff;
   reg [`MASK_W-1:0] size_mask_ff;

   reg [31:0] nxt_rdata;
   wire xl_hit;
   wire [31:0] xl_addr;

   wire [3:0] wr_sel;
   wire [3:0] rd_sel;
   wire wr_pm;
   wire wr_xlat;
   wire wr_base;

   // Bit positions of the one-hot select returned by reg_decode
   localparam SEL_PM = 0;
   localparam SEL_XLAT = 1;
   localparam SEL_SETUP = 2;
   localparam SEL_BASE = 3;

   // Shared by the write and read paths so that a register can never be
   // writable at one offset and readable at another
   function [3:0] reg_decode;
      input [7:0] a;
      begin
         // Unmapped offsets select nothing and read as zero
         reg_decode = 4'h0;
         if (a == `OFF_PM_CTRL_STATUS) begin
            reg_decode[SEL_PM] = 1'b1;
         end else if (a == `OFF_WIN0_XLAT_BASE) begin
            reg_decode[SEL_XLAT] = 1'b1;
         end else if (a == `OFF_WIN0_SETUP ||
                      a == `OFF_WIN0_SETUP_DOC) begin
            reg_decode[SEL_SETUP] = 1'b1;
         end else if (a == `OFF_WIN0_BASE) begin
            reg_decode[SEL_BASE] = 1'b1;
         end
      end
   endfunction

   // Writable page bits of the window base: top bit plus mask ones
   function [`PAGE_W-1:0] page_sel;
      input [`MASK_W-1:0] mask;
      begin
         page_sel = {1'b1, mask};
      end
   endfunction

   function [31:0] setup_word;
      input [1:0] aw;
      input pf;
      input [`MASK_W-1:0] mask;
      begin
         setup_word = 32'h00000000;
         setup_word[`SETUP_ENABLE_BIT] = WIN_ENABLE;
         setup_word[`SETUP_MASK_MSB:`SETUP_MASK_LSB] = mask;
         setup_word[`SETUP_PREFETCH_BIT] = pf;
         setup_word[`SETUP_AWIDTH_MSB:`SETUP_AWIDTH_LSB] = aw;
         setup_word[`SETUP_TYPE_BIT] = 1'b0;
      end
   endfunction

   // Absent power data and bridge support facilities read as zero
   function [31:0] pm_word;
      input [1:0] state;
      input en;
      input sts;
      begin
         pm_word = 32'h00000000;
         pm_word[`PM_STATE_MSB:`PM_STATE_LSB] = state;
         pm_word[`PM_EVT_EN_BIT] = en;
         pm_word[`PM_EVT_STS_BIT] = sts;
      end
   endfunction

   assign wr_sel = i_wr ? reg_decode(i_addr) : 4'h0;
   assign rd_sel = i_rd ? reg_decode(i_addr) : 4'h0;
   assign wr_pm = wr_sel[SEL_PM];
   assign wr_xlat = wr_sel[SEL_XLAT];
   assign wr_base = wr_sel[SEL_BASE];

   // Power state next value
   always @* begin
      nxt_pm_state = pm_state_ff;
      nxt_soft_rst = 1'b0;
      if (wr_pm) begin
         if (i_wdata[`PM_STATE_MSB:`PM_STATE_LSB] == `PM_STATE_D0 ||
             i_wdata[`PM_STATE_MSB:`PM_STATE_LSB] == `PM_STATE_D3) begin
            nxt_pm_state = i_wdata[`PM_STATE_MSB:`PM_STATE_LSB];
         end
         if (pm_state_ff == `PM_STATE_D3 &&
             i_wdata[`PM_STATE_MSB:`PM_STATE_LSB] == `PM_STATE_D0) begin
            nxt_soft_rst = 1'b1;
         end
      end
   end

   // Sticky bits ignore the internal reset
   always @* begin
      nxt_evt_en = evt_en_ff;
      nxt_evt_sts = evt_sts_ff;
      if (wr_pm) begin
         nxt_evt_en = i_wdata[`PM_EVT_EN_BIT];
      end
      if (wr_pm && i_wdata[`PM_EVT_STS_BIT]) begin
         nxt_evt_sts = 1'b0;
      end
      if (i_power_event) begin
         nxt_evt_sts = 1'b1;
      end
   end

   // sticky bits cleared by power-on reset only
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         evt_en_ff <= 1'b0;
         evt_sts_ff <= 1'b0;
      end else begin
         evt_en_ff <= nxt_evt_en;
         evt_sts_ff <= nxt_evt_sts;
      end
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pm_state_ff <= `RST_PM_STATE;
         soft_rst_ff <= 1'b0;
      end else begin
         pm_state_ff <= nxt_pm_state;
         soft_rst_ff <= nxt_soft_rst;
      end
   end

   // Window base and translated base next values
   always @* begin
      nxt_xlat_base = xlat_base_ff;
      nxt_win_base = win_base_ff;
      if (soft_rst_ff) begin
         nxt_xlat_base = `RST_XLAT_BASE;
         nxt_win_base = `RST_WIN_BASE;
      end else begin
         if (wr_xlat) begin
            nxt_xlat_base = i_wdata[31:`PAGE_LSB];
         end
         if (wr_base) begin
            nxt_win_base = (i_wdata[31:`PAGE_LSB] & page_sel(size_mask_ff)) |
                           (win_base_ff & ~page_sel(size_mask_ff));
         end
      end
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         xlat_base_ff <= `RST_XLAT_BASE;
         win_base_ff <= `RST_WIN_BASE;
      end else begin
         xlat_base_ff <= nxt_xlat_base;
         win_base_ff <= nxt_win_base;
      end
   end

   // Setup fields take only the preload path; host writes never reach them.
   // Preload is not disturbed by the internal reset, which keeps the
   // window geometry stable across a D3 to D0 cycle.
   // preload-only setup fields
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         awidth_ff <= `RST_AWIDTH;
         prefetch_ff <= `RST_PREFETCH;
         size_mask_ff <= `RST_SIZE_MASK;
      end else if (i_preload_valid) begin
         awidth_ff <= i_preload_data[`SETUP_AWIDTH_MSB:`SETUP_AWIDTH_LSB];
         prefetch_ff <= i_preload_data[`SETUP_PREFETCH_BIT];
         size_mask_ff <= i_preload_data[`SETUP_MASK_MSB:`SETUP_MASK_LSB];
      end
   end

   // Read mux; data appears the cycle after the strobe and only then
   always @* begin
      nxt_rdata = 32'h00000000;
      if (rd_sel[SEL_PM]) begin
         nxt_rdata = pm_word(pm_state_ff, evt_en_ff, evt_sts_ff);
      end else if (rd_sel[SEL_XLAT]) begin
         nxt_rdata = {xlat_base_ff, 12'h000};
      end else if (rd_sel[SEL_SETUP]) begin
         nxt_rdata = setup_word(awidth_ff, prefetch_ff, size_mask_ff);
      end else if (rd_sel[SEL_BASE]) begin
         nxt_rdata = {win_base_ff, 12'h000};
      end else begin
         nxt_rdata = 32'h00000000;
      end
   end

   dn_window_xlat u_xlat (
      .i_addr(i_dn_addr),
      .i_win_base(win_base_ff),
      .i_xlat_base(xlat_base_ff),
      .i_size_mask(size_mask_ff),
      .i_enable(WIN_ENABLE),
      .o_hit(xl_hit),
      .o_addr(xl_addr)
   );

   // Registered outputs
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h00000000;
         o_power_event_out_n <= 1'b1;
         o_power_state <= `RST_PM_STATE;
         o_internal_reset <= 1'b0;
         o_dn_valid <= 1'b0;
         o_dn_hit <= 1'b0;
         o_dn_addr <= 32'h00000000;
      end else begin
         o_rdata <= nxt_rdata;
         o_power_event_out_n <= ~(nxt_evt_sts & nxt_evt_en);
         o_power_state <= nxt_pm_state;
         o_internal_reset <= nxt_soft_rst;
         o_dn_valid <= i_dn_valid;
         o_dn_hit <= i_dn_valid & xl_hit;
         o_dn_addr <= xl_addr;
      end
   end
endmodule // bridge_pm_window_regs

// [core/dn_window_xlat.v]
`timescale 1ns/1ns
`include "bridge_pm_window_defines.vh"

module dn_window_xlat (
   input wire [31:0] i_addr,
   input wire [`PAGE_W-1:0] i_win_base,
   input wire [`PAGE_W-1:0] i_xlat_base,
   input wire [`MASK_W-1:0] i_size_mask,
   input wire i_enable,
   output wire o_hit,
   output wire [31:0] o_addr
);
   // Top page bit always decodes; mask ones mark compared/replaced bits
   wire [`PAGE_W-1:0] sel;
   wire [`PAGE_W-1:0] page;

   assign sel = {1'b1, i_size_mask};
   assign page = i_addr[31:`PAGE_LSB];
   assign o_hit = i_enable & ((page & sel) == (i_win_base & sel));
   assign o_addr = o_hit ?
      {(i_xlat_base & sel) | (page & ~sel), i_addr[`PAGE_LSB-1:0]} : i_addr;
endmodule // dn_window_xlat

// [tb/bridge_pm_window_regs_asserts.sv]
`timescale 1ns/1ns
module bridge_pm_window_regs_asserts (
   input logic i_sys_clk,
   input logic i_rst,
   input logic [7:0] i_addr,
   input logic [31:0] i_wdata,
   input logic i_wr,
   input logic i_rd,
   input logic [31:0] o_rdata,
   input logic [1:0] o_power_state,
   input logic o_internal_reset,
   input logic [31:0] i_dn_addr,
   input logic o_dn_valid,
   input logic o_dn_hit,
   input logic [31:0] o_dn_addr
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire pm_wr = i_wr && i_addr == 8'h94;
   sequence s_in_d3; o_power_state == 2'h3; endsequence
   sequence s_wake; pm_wr && i_wdata[1:0] == 2'h0; endsequence
   a_gap_keeps_state: assert property (
      pm_wr && i_wdata[1:0] inside {2'h1, 2'h2} |=> $stable(o_power_state))
      else $error("unimplemented power state accepted");
   a_state_takes_code: assert property (
      pm_wr && i_wdata[0] == i_wdata[1] |=> o_power_state == $past(i_wdata[1:0]))
      else $error("power state write lost");
   a_wake_resets: assert property (s_in_d3 ##0 s_wake |=> o_internal_reset)
      else $error("no internal reset on wake");
   a_reset_has_cause: assert property (
      o_internal_reset |-> $past(pm_wr) && $past(o_power_state) == 2'h3 ##1 !o_internal_reset)
      else $error("internal reset without wake or too long");
   a_pm_zero_bits: assert property (
      i_rd && i_addr == 8'h94 |=> (o_rdata & 32'hffff7efc) == 32'h0)
      else $error("power word fixed bits not zero");
   a_xlat_low_zero: assert property (
      i_rd && i_addr == 8'h98 |=> o_rdata[11:0] == 12'h000)
      else $error("translated base low bits not zero");
   a_setup_fixed_bits: assert property (
      i_rd && i_addr == 8'h9c |=> o_rdata[31] && o_rdata[11:4] == 8'h00 && !o_rdata[0])
      else $error("setup fixed bits wrong");
   a_miss_passes: assert property (
      o_dn_valid && !o_dn_hit |-> o_dn_addr == $past(i_dn_addr))
      else $error("missed address altered");
   a_hit_keeps_offset: assert property (
      o_dn_hit |-> o_dn_valid && o_dn_addr[11:0] == $past(i_dn_addr[11:0]))
      else $error("hit altered page offset");
endmodule // bridge_pm_window_regs_asserts

bind bridge_pm_window_regs bridge_pm_window_regs_asserts u_chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_power_state(o_power_state),
   .o_internal_reset(o_internal_reset), .i_dn_addr(i_dn_addr),
   .o_dn_valid(o_dn_valid), .o_dn_hit(o_dn_hit), .o_dn_addr(o_dn_addr));

// [tb/cfg_host_model.sv]
`timescale 1ns/1ns
module cfg_host_model (
   input wire i_sys_clk,
   output logic [7:0] o_addr = 8'h00,
   output logic [31:0] o_wdata = 32'h0,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   input wire [31:0] i_rdata
);
   // Released lines are inverted so stale values are never mistaken for data
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_sys_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_sys_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_sys_clk);
      d = i_rdata;
   endtask
endmodule // cfg_host_model

// [tb/tb_bridge_pm_window_regs.sv]
`timescale 1ns/1ns
module tb_bridge_pm_window_regs;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d, dn_out;
   logic [31:0] pre_data = 32'h0, dn_in = 32'h0;
   logic wr, rd, evt_n, irst, dn_v, dn_hit;
   logic pre_vld = 1'b0, evt = 1'b0, dn_vld = 1'b0;
   logic [1:0] pstate;
   int mismatches = 0, num_checks = 0, cycles = 0, irst_cnt = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   cfg_host_model host (.i_sys_clk(i_sys_clk), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   bridge_pm_window_regs DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_preload_valid(pre_vld), .i_preload_data(pre_data),
      .i_power_event(evt), .o_power_event_out_n(evt_n),
      .o_power_state(pstate), .o_internal_reset(irst), .i_dn_valid(dn_vld),
      .i_dn_addr(dn_in), .o_dn_valid(dn_v), .o_dn_hit(dn_hit),
      .o_dn_addr(dn_out));
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      host.rd(a, d);
      chk(n, e, d);
   endtask
   task pulse_event;
      @(posedge i_sys_clk);
      evt <= 1'b1;
      @(posedge i_sys_clk);
      evt <= 1'b0;
   endtask
   task dn(input logic [31:0] a, input logic h, input logic [31:0] e);
      @(posedge i_sys_clk);
      dn_vld <= 1'b1;
      dn_in <= a;
      @(posedge i_sys_clk);
      dn_vld <= 1'b0;
      dn_in <= ~a;
      @(posedge i_sys_clk);
      chk("dn valid", 32'h1, {31'h0, dn_v});
      chk("dn hit", {31'h0, h}, {31'h0, dn_hit});
      chk("dn addr", e, dn_out);
   endtask
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (irst === 1'b1) begin
         irst_cnt <= irst_cnt + 1;
      end
      if (cycles == 3000) begin
         mismatches++;
         final_report;
      end
   end
   initial begin
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rchk("pm", 8'h94, 32'h0);
      rchk("xbase", 8'h98, 32'h0);
      rchk("setup", 8'h9c, 32'hfffff000);
      host.wr(8'h10, 32'hffffffff);
      rchk("unmapped", 8'h10, 32'h0);
      $display("test reset done");
      host.wr(8'h94, 32'hffffffff);
      rchk("pm d3", 8'h94, 32'h00000103);
      for (int c = 1; c < 3; c++) begin
         host.wr(8'h94, 32'h100 | c);
         rchk("pm gap", 8'h94, 32'h103);
      end
      chk("state", 32'h3, {30'h0, pstate});
      pulse_event;
      rchk("pm evt", 8'h94, 32'h8103);
      chk("evt pin", 32'h0, {31'h0, evt_n});
      host.wr(8'h94, 32'h8103);
      rchk("pm clr", 8'h94, 32'h103);
      host.wr(8'h94, 32'h3);
      pulse_event;
      rchk("pm off", 8'h94, 32'h8003);
      chk("evt gated", 32'h1, {31'h0, evt_n});
      $display("test power done");
      host.wr(8'h98, 32'habcde123);
      rchk("xbase rw", 8'h98, 32'habcde000);
      // Wake from D3 with enable set: sticky status must survive
      host.wr(8'h94, 32'h100);
      repeat (3) @(posedge i_sys_clk);
      chk("soft resets", 32'h1, irst_cnt);
      rchk("xbase wake", 8'h98, 32'h0);
      rchk("pm wake", 8'h94, 32'h8100);
      chk("evt on", 32'h0, {31'h0, evt_n});
      $display("test wake done");
      @(posedge i_sys_clk);
      pre_vld <= 1'b1;
      pre_data <= 32'h7fff0ffb;
      @(posedge i_sys_clk);
      pre_vld <= 1'b0;
      pre_data <= 32'h0;
      rchk("preload", 8'h9c, 32'hffff000a);
      host.wr(8'h9c, 32'h0);
      rchk("setup ro", 8'h9c, 32'hffff000a);
      host.wr(8'hc4, 32'hffffffff);
      rchk("win base", 8'hc4, 32'hffff0000);
      host.wr(8'h98, 32'h12345000);
      dn(32'hffff4567, 1'b1, 32'h12344567);
      dn(32'h00001234, 1'b0, 32'h00001234);
      $display("test window done");
      // Second wake: window base clears, preload and sticky status survive
      host.wr(8'h94, 32'h3);
      host.wr(8'h94, 32'h0);
      rchk("base wake", 8'hc4, 32'h0);
      rchk("setup wake", 8'h9c, 32'hffff000a);
      rchk("pm sticky", 8'h94, 32'h8000);
      chk("soft twice", 32'h2, irst_cnt);
      // Power-on reset in mid-run clears the sticky bits
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rchk("pm por", 8'h94, 32'h0);
      rchk("setup por", 8'h9c, 32'hfffff000);
      $display("test por done");
      final_report;
   end
endmodule // tb_bridge_pm_window_regs
